// ===== dss_sequencer.sv
// drive start/stop sequencer: start modes, stop modes, pre-heat, safety stop
// assumes settings come from keypad logic on sys_clk; preheat_input and power_fail are pins
`include "dss_params.svh"
module dss_sequencer #(
  parameter int TICK_CYCLES = `DSS_TICK_US * `DSS_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run_cmd,
  input wire logic reverse_cmd,
  input wire logic [15:0] cmd_frequency,
  input wire logic [15:0] start_frequency,
  input wire logic [15:0] max_frequency,
  input wire logic [15:0] accel_time,
  input wire logic [15:0] decel_time,
  input wire logic scurve_enable,
  input wire logic [7:0] curve_start_ratio,
  input wire logic [7:0] curve_end_ratio,
  input wire logic [1:0] start_method_select,
  input wire logic [9:0] magnetize_duration,
  input wire logic [7:0] magnetize_level,
  input wire logic sensorless_mode,
  input wire logic [15:0] motor_speed_est,
  input wire logic motor_reverse,
  input wire logic [1:0] stop_method_select,
  input wire logic [7:0] brake_hold_time,
  input wire logic [15:0] brake_start_frequency,
  input wire logic [7:0] brake_duration,
  input wire logic [7:0] brake_level,
  input wire logic safety_stop_enable,
  input wire logic power_fail,
  input wire logic [7:0] load_inertia_ratio,
  input wire logic [11:0] motor_rated_current,
  input wire logic preheat_enable,
  input wire logic preheat_input_assigned,
  input wire logic preheat_input,
  input wire logic [7:0] preheat_current_level,
  input wire logic [7:0] preheat_duty,
  input wire logic param_write_req,
  output logic [15:0] out_frequency,
  output logic gate_enable,
  output logic dc_inject,
  output logic [15:0] dc_current,
  output logic flux_brake,
  output logic running,
  output logic preheat_active,
  output logic param_write_ok
);
  dss_pkg::dss_state_e state_reg;
  dss_pkg::dss_state_e state_next;
  logic [1:0] rst_sync_reg;
  logic rst_sync_n;
  logic [1:0] ph_sync_reg;
  logic [1:0] pf_sync_reg;
  logic ph_in_s;
  logic pf_s;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] tmr_reg;
  logic tmr_load;
  logic [15:0] tmr_val;
  logic [1:0] stop_reg;
  logic [1:0] stop_next;
  logic rload;
  logic [15:0] rload_val;
  logic [15:0] ph_ms_reg;
  logic preheat_on;
  logic ph_dc;
  logic [9:0] mag_dur_c;
  logic [7:0] mag_lvl_c;
  logic mag_go;
  logic [31:0] safe_t;
  logic gate_c;
  logic dc_c;
  logic [15:0] cur_c;
  logic [15:0] freq_c;

  dss_ramp_if rif ();

  dss_ramp u_ramp (
    .clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .rif(rif)
  );

  function automatic logic [15:0] ms_of(input logic [15:0] t);
    ms_of = 16'(t * `DSS_MS_PER_TENTH);
  endfunction

  // percent of rated current, 0.1 A units
  function automatic logic [15:0] pct_of(input logic [7:0] lvl, input logic [11:0] rated);
    logic [19:0] p;
    p = {12'h000, lvl} * {8'h00, rated};
    pct_of = 16'(p / `DSS_PCT_DIV);
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_reg[1];

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph_sync_reg <= 2'h0;
      pf_sync_reg <= 2'h0;
    end else begin
      ph_sync_reg <= {ph_sync_reg[0], preheat_input};
      pf_sync_reg <= {pf_sync_reg[0], power_fail};
    end
  end
  assign ph_in_s = ph_sync_reg[1];
  assign pf_s = pf_sync_reg[1];

  // ms time base for all sequence timers
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // out-of-range settings clamp to the top of range
  assign mag_dur_c = (magnetize_duration > `DSS_MAG_DUR_MAX) ? `DSS_MAG_DUR_MAX : magnetize_duration;
  assign mag_lvl_c = (magnetize_level > `DSS_MAG_LVL_MAX) ? `DSS_MAG_LVL_MAX : magnetize_level;
  // DC start only with time, level and no sensorless
  assign mag_go = (mag_dur_c != 10'h000) && (mag_lvl_c != 8'h00) && !sensorless_mode;

  // safety decel time grows with load inertia
  assign safe_t = ({16'h0000, decel_time} * (`DSS_INERTIA_BASE + {24'h000000, load_inertia_ratio}))
                  / `DSS_INERTIA_BASE;

  always_comb begin
    state_next = state_reg;
    stop_next = stop_reg;
    tmr_load = 1'b0;
    tmr_val = 16'h0000;
    rload = 1'b0;
    rload_val = start_frequency;
    case (state_reg)
      dss_pkg::ST_STOP: begin
        if (run_cmd && !pf_s) begin
          rload = 1'b1;
          case (start_method_select)
            `DSS_START_DC: begin
              if (mag_go) begin
                state_next = dss_pkg::ST_MAG;
                tmr_load = 1'b1;
                tmr_val = ms_of({6'h00, mag_dur_c});
              end else begin
                state_next = dss_pkg::ST_RUN;
              end
            end
            `DSS_START_FLY: state_next = dss_pkg::ST_SEARCH;
            default: state_next = dss_pkg::ST_RUN;
          endcase
        end
      end
      dss_pkg::ST_MAG: begin
        if (!run_cmd) begin
          state_next = dss_pkg::ST_STOP;
        end else if (tmr_reg == 16'h0000) begin
          state_next = dss_pkg::ST_RUN;
        end
      end
      dss_pkg::ST_SEARCH: begin
        // catch opposite rotation only below half speed
        if (!run_cmd) begin
          state_next = dss_pkg::ST_STOP;
        end else if (motor_reverse == reverse_cmd) begin
          rload = 1'b1;
          rload_val = motor_speed_est;
          state_next = dss_pkg::ST_RUN;
        end else if (motor_speed_est < (max_frequency >> 1)) begin
          rload = 1'b1;
          state_next = dss_pkg::ST_RUN;
        end
      end
      dss_pkg::ST_RUN: begin
        if (pf_s) begin
          // power loss: safety decel or coast
          state_next = safety_stop_enable ? dss_pkg::ST_SAFE : dss_pkg::ST_STOP;
        end else if (!run_cmd) begin
          stop_next = stop_method_select;
          // stop decode, coast cuts output now
          state_next = (stop_method_select == `DSS_STOP_COAST) ? dss_pkg::ST_STOP : dss_pkg::ST_DECEL;
        end
      end
      dss_pkg::ST_DECEL: begin
        if (pf_s) begin
          state_next = safety_stop_enable ? dss_pkg::ST_SAFE : dss_pkg::ST_STOP;
        end else if (run_cmd) begin
          state_next = dss_pkg::ST_RUN;
        end else if (rif.at_target) begin
          if (stop_reg == `DSS_STOP_DCBRAKE) begin
            state_next = dss_pkg::ST_HOLD;
            tmr_load = 1'b1;
            tmr_val = ms_of({8'h00, brake_hold_time});
          end else begin
            state_next = dss_pkg::ST_STOP;
          end
        end
      end
      dss_pkg::ST_HOLD: begin
        if (tmr_reg == 16'h0000) begin
          state_next = dss_pkg::ST_BRAKE;
          tmr_load = 1'b1;
          tmr_val = ms_of({8'h00, brake_duration});
        end
      end
      dss_pkg::ST_BRAKE: begin
        if (tmr_reg == 16'h0000) begin
          state_next = dss_pkg::ST_STOP;
        end
      end
      dss_pkg::ST_SAFE: begin
        if (rif.at_target) begin
          state_next = dss_pkg::ST_STOP;
        end
      end
      default: state_next = dss_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= dss_pkg::ST_STOP;
      stop_reg <= `DSS_STOP_DECEL;
    end else begin
      state_reg <= state_next;
      stop_reg <= stop_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmr_reg <= 16'h0000;
    end else if (tmr_load) begin
      tmr_reg <= tmr_val;
    end else if (tick && tmr_reg != 16'h0000) begin
      tmr_reg <= tmr_reg - 16'h0001;
    end
  end

  // DC brake decelerates to brake frequency
  always_comb begin
    case (state_reg)
      dss_pkg::ST_MAG: rif.target = start_frequency;
      dss_pkg::ST_RUN: rif.target = cmd_frequency;
      dss_pkg::ST_DECEL: rif.target = (stop_reg == `DSS_STOP_DCBRAKE) ? brake_start_frequency : 16'h0000;
      default: rif.target = 16'h0000;
    endcase
  end
  assign rif.tick = tick;
  assign rif.load = rload;
  assign rif.load_val = rload_val;
  assign rif.max_freq = max_frequency;
  assign rif.accel_t = accel_time;
  assign rif.decel_t = (state_reg == dss_pkg::ST_SAFE) ?
                       ((safe_t > `DSS_TIME_MAX) ? 16'hFFFF : safe_t[15:0]) : decel_time;
  assign rif.s_ratio = curve_start_ratio;
  assign rif.e_ratio = curve_end_ratio;
  assign rif.scurve = scurve_enable;

  // pre-heat window, run ends it
  // waits for running to drop so a coast stop shows its output cut first
  assign preheat_on = (state_reg == dss_pkg::ST_STOP) && preheat_enable && preheat_input_assigned
                      && ph_in_s && !run_cmd && !running;

  // ten-second duty frame restarts whenever pre-heat starts
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ph_ms_reg <= 16'h0000;
    end else if (!preheat_on) begin
      ph_ms_reg <= 16'h0000;
    end else if (tick) begin
      ph_ms_reg <= (ph_ms_reg == `DSS_PREHEAT_PERIOD_MS - 16'h0001) ? 16'h0000 : ph_ms_reg + 16'h0001;
    end
  end
  // duty share of the frame, full at 100%
  assign ph_dc = preheat_on && ((preheat_duty >= `DSS_PCT_FULL) ||
                 (ph_ms_reg < 16'({8'h00, preheat_duty} * `DSS_PREHEAT_MS_PER_PCT)));

  assign param_write_ok = param_write_req && !preheat_on;

  always_comb begin
    gate_c = 1'b0;
    dc_c = 1'b0;
    cur_c = 16'h0000;
    freq_c = 16'h0000;
    case (state_reg)
      dss_pkg::ST_MAG: begin
        gate_c = 1'b1;
        dc_c = 1'b1;
        cur_c = pct_of(mag_lvl_c, motor_rated_current);
        freq_c = rif.freq;
      end
      dss_pkg::ST_RUN, dss_pkg::ST_DECEL, dss_pkg::ST_SAFE: begin
        gate_c = 1'b1;
        freq_c = rif.freq;
      end
      dss_pkg::ST_BRAKE: begin
        gate_c = 1'b1;
        dc_c = 1'b1;
        cur_c = pct_of(brake_level, motor_rated_current);
      end
      dss_pkg::ST_STOP: begin
        gate_c = ph_dc;
        dc_c = ph_dc;
        cur_c = ph_dc ? pct_of(preheat_current_level, motor_rated_current) : 16'h0000;
      end
      default: gate_c = 1'b0;
    endcase
  end

  // outputs lag state by one cycle so the power stage sees glitch-free levels
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_frequency <= 16'h0000;
      gate_enable <= 1'b0;
      dc_inject <= 1'b0;
      dc_current <= 16'h0000;
      flux_brake <= 1'b0;
      running <= 1'b0;
      preheat_active <= 1'b0;
    end else begin
      out_frequency <= freq_c;
      gate_enable <= gate_c;
      dc_inject <= dc_c;
      dc_current <= cur_c;
      flux_brake <= (state_reg == dss_pkg::ST_DECEL) && (stop_reg == `DSS_STOP_FLUX);
      running <= (state_reg != dss_pkg::ST_STOP);
      preheat_active <= preheat_on;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_coast;
    state_reg == dss_pkg::ST_RUN && !pf_s && !run_cmd && stop_method_select == `DSS_STOP_COAST
      |-> ##2 !gate_enable && out_frequency == 16'h0000;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop kept output");
  property p_preheat_stop;
    preheat_active |-> $past(state_reg == dss_pkg::ST_STOP && preheat_enable && ph_in_s);
  endproperty
  a_preheat_stop: assert property (p_preheat_stop) else $error("pre-heat outside stop");
  property p_param_block;
    preheat_on && param_write_req |-> !param_write_ok;
  endproperty
  a_param_block: assert property (p_param_block) else $error("write accepted in pre-heat");
  property p_dc_skip;
    state_reg == dss_pkg::ST_STOP && run_cmd && !pf_s && start_method_select == `DSS_START_DC
      && (magnetize_duration == 10'h000 || magnetize_level == 8'h00) |=> state_reg == dss_pkg::ST_RUN;
  endproperty
  a_dc_skip: assert property (p_dc_skip) else $error("DC start not skipped");
  property p_sensorless;
    $rose(state_reg == dss_pkg::ST_MAG) |-> $past(!sensorless_mode);
  endproperty
  a_sensorless: assert property (p_sensorless) else $error("DC start in sensorless");
  property p_mag_dc;
    state_reg == dss_pkg::ST_MAG ##1 state_reg == dss_pkg::ST_MAG |-> dc_inject && gate_enable;
  endproperty
  a_mag_dc: assert property (p_mag_dc) else $error("no DC while magnetizing");
  property p_hold_off;
    $past(state_reg) == dss_pkg::ST_HOLD |-> !gate_enable && !dc_inject;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output during brake hold");
  property p_brake_end;
    state_reg == dss_pkg::ST_BRAKE && tmr_reg == 16'h0000 |=> state_reg == dss_pkg::ST_STOP ##1 !dc_inject;
  endproperty
  a_brake_end: assert property (p_brake_end) else $error("brake did not end");
  property p_preheat_end;
    preheat_active && (run_cmd || !ph_in_s) |=> !preheat_active;
  endproperty
  a_preheat_end: assert property (p_preheat_end) else $error("pre-heat outlived input");
  property p_duty_full;
    preheat_on && preheat_duty >= `DSS_PCT_FULL |=> dc_inject;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty not continuous");
  property p_safe;
    state_reg == dss_pkg::ST_RUN && pf_s && safety_stop_enable |=> state_reg == dss_pkg::ST_SAFE;
  endproperty
  a_safe: assert property (p_safe) else $error("no safety decel");

  c_brake: cover property (state_reg == dss_pkg::ST_HOLD ##[1:1000] state_reg == dss_pkg::ST_BRAKE);
  c_preheat: cover property (preheat_active && dc_inject);
  c_safe: cover property (state_reg == dss_pkg::ST_SAFE ##[1:1000] state_reg == dss_pkg::ST_STOP);
  c_fly: cover property (state_reg == dss_pkg::ST_SEARCH ##1 state_reg == dss_pkg::ST_RUN);
endmodule

// ===== dss_params.svh
// constants for the drive start/stop sequencer
// assumes a 100 MHz system clock and a keypad that holds settings steady
// Overview of operation
// - S-curve stretches accel time by both ratios
// - S-curve stretches decel time the same way
// - Pre-heat only when stopped, enabled, input on
// - Pre-heat current is percent of rated current
// - Pre-heat duty over ten seconds; 100% continuous
// - Parameter writes refused while pre-heat runs
// - Start select: accel, DC start, flying start
// - DC start holds start frequency, then accelerates
// - DC start skipped if time or level zero
// - No DC start in sensorless mode
// - Magnetize duration 0 to 60 s, default 0
// - Magnetize level 0 to 150 percent, default 50
// - Stop select: decel, DC brake, coast, flux
// - Coast stop removes output at once
// - DC brake ramps to brake frequency first
// - Output blocked for hold time before injection
// - Injection lasts brake duration, then stop ends
// - Brake level scaled by motor rated current
// - Brake settings used only in DC-brake mode
// - Safety stop decelerates on power loss, inertia-scaled
// - Flying start opposite direction only below half
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
`define DSS_CLK_MHZ 100
`define DSS_TICK_US 1000
`define DSS_MS_PER_TENTH 16'h0064
`define DSS_CURVE_DIV 32'h0000_00C8
`define DSS_PCT_FULL 8'h64
`define DSS_PCT_DIV 20'h0_0064
`define DSS_PREHEAT_PERIOD_S 16'h000A
`define DSS_PREHEAT_PERIOD_MS (`DSS_PREHEAT_PERIOD_S * 16'h03E8)
`define DSS_PREHEAT_MS_PER_PCT (`DSS_PREHEAT_PERIOD_MS / 16'h0064)
`define DSS_START_ACCEL 2'h0
`define DSS_START_DC 2'h1
`define DSS_START_FLY 2'h2
`define DSS_STOP_DECEL 2'h0
`define DSS_STOP_DCBRAKE 2'h1
`define DSS_STOP_COAST 2'h2
`define DSS_STOP_FLUX 2'h3
`define DSS_MAG_DUR_MAX 10'h258
`define DSS_MAG_DUR_DEFAULT 10'h000
`define DSS_MAG_LVL_MAX 8'h96
`define DSS_MAG_LVL_DEFAULT 8'h32
`define DSS_SAFETY_DEFAULT 1'h0
`define DSS_INERTIA_BASE 32'h0000_000A
`define DSS_TIME_MAX 32'h0000_FFFF
`endif

// ===== dss_pkg.sv
// types and shared arithmetic of the start/stop sequencer
// assumes dss_params.svh is on the include path
`include "dss_params.svh"
package dss_pkg;
  typedef enum logic [3:0] {
    ST_STOP, ST_MAG, ST_SEARCH, ST_RUN, ST_DECEL, ST_HOLD, ST_BRAKE, ST_SAFE
  } dss_state_e;

  // tenths of a second to ms, stretched by the two curve ratios
  function automatic logic [31:0] dss_stretch_ms(input logic [15:0] t, input logic [7:0] s,
                                                 input logic [7:0] e, input logic en);
    logic [31:0] base;
    base = {16'h0000, t} * {16'h0000, `DSS_MS_PER_TENTH};
    dss_stretch_ms = en ? base + (base * ({24'h000000, s} + {24'h000000, e})) / `DSS_CURVE_DIV : base;
  endfunction

  // frequency step per ms so that full scale takes ms; truncation makes ramps slightly slow
  function automatic logic [15:0] dss_ramp_step(input logic [15:0] fmax, input logic [31:0] ms);
    logic [31:0] q;
    q = (ms == 32'h0) ? {16'h0000, fmax} : {16'h0000, fmax} / ms;
    dss_ramp_step = (q == 32'h0) ? 16'h0001 : q[15:0];
  endfunction
endpackage

// ===== dss_ramp_if.sv
// carrier between sequencer control and the frequency ramp
// assumes both ends run on the same clock
interface dss_ramp_if;
  logic tick;
  logic load;
  logic [15:0] load_val;
  logic [15:0] target;
  logic [15:0] max_freq;
  logic [15:0] accel_t;
  logic [15:0] decel_t;
  logic [7:0] s_ratio;
  logic [7:0] e_ratio;
  logic scurve;
  logic [15:0] freq;
  logic at_target;
  modport seq (output tick, load, load_val, target, max_freq, accel_t, decel_t, s_ratio, e_ratio,
               scurve, input freq, at_target);
  modport ramp (input tick, load, load_val, target, max_freq, accel_t, decel_t, s_ratio, e_ratio,
                scurve, output freq, at_target);
endinterface

// ===== dss_ramp.sv
// frequency ramp generator, one step per ms tick
// assumes a synchronous active-low reset copy and a one-cycle tick
module dss_ramp (
  input wire logic clk,
  input wire logic rst_sync_n,
  dss_ramp_if.ramp rif
);
  logic [15:0] freq_reg;
  logic [15:0] up_step;
  logic [15:0] dn_step;

  assign up_step = dss_pkg::dss_ramp_step(rif.max_freq,
                   dss_pkg::dss_stretch_ms(rif.accel_t, rif.s_ratio, rif.e_ratio, rif.scurve));
  assign dn_step = dss_pkg::dss_ramp_step(rif.max_freq,
                   dss_pkg::dss_stretch_ms(rif.decel_t, rif.s_ratio, rif.e_ratio, rif.scurve));

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      freq_reg <= 16'h0000;
    end else if (rif.load) begin
      freq_reg <= rif.load_val;
    end else if (rif.tick) begin
      if (freq_reg < rif.target) begin
        freq_reg <= (rif.target - freq_reg > up_step) ? 16'(freq_reg + up_step) : rif.target;
      end else if (freq_reg > rif.target) begin
        freq_reg <= (freq_reg - rif.target > dn_step) ? 16'(freq_reg - dn_step) : rif.target;
      end
    end
  end

  assign rif.freq = freq_reg;
  assign rif.at_target = (freq_reg == rif.target);

  property p_ramp_up;
    @(posedge clk) disable iff (!rst_sync_n)
    rif.tick && !rif.load && freq_reg < rif.target |=> freq_reg == $past(freq_reg) +
      (($past(rif.target) - $past(freq_reg) > $past(up_step)) ? $past(up_step) : $past(rif.target) - $past(freq_reg));
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("accel step wrong");
  property p_ramp_dn;
    @(posedge clk) disable iff (!rst_sync_n)
    rif.tick && !rif.load && freq_reg > rif.target |=> freq_reg < $past(freq_reg) && freq_reg >= $past(rif.target);
  endproperty
  a_ramp_dn: assert property (p_ramp_dn) else $error("decel step wrong");
endmodule

// ===== dss_motor_model.sv
// motor and power stage stand-in for the sequencer bench
// assumes the sequencer's registered outputs on sys_clk
module dss_motor_model (
  input wire logic clk,
  input wire logic gate_enable,
  input wire logic dc_inject,
  input wire logic [15:0] out_frequency,
  output logic [15:0] motor_speed_est,
  output logic motor_reverse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] spd_reg = 16'h0000;
  // shaft tracks drive, dc holds it, coasting spins down slowly
  always_ff @(posedge clk) begin
    if (dc_inject) begin
      spd_reg <= 16'h0000;
    end else if (gate_enable) begin
      spd_reg <= out_frequency;
    end else if (spd_reg != 16'h0000) begin
      spd_reg <= spd_reg - 16'h0001;
    end
  end
  assign motor_speed_est = spd_reg;
  assign motor_reverse = 1'b0;
endmodule

// ===== tb_drive_start_stop_sequencer.sv
// self-checking bench of the start/stop sequencer
// assumes ms ticks shortened to 10 cycles and the motor stand-in model
module tb_drive_start_stop_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, run_cmd, reverse_cmd, scurve_enable, sensorless_mode, motor_reverse;
  logic safety_stop_enable, power_fail, preheat_enable, preheat_input_assigned, preheat_input;
  logic param_write_req, gate_enable, dc_inject, flux_brake, running, preheat_active, param_write_ok;
  logic [15:0] cmd_frequency, start_frequency, max_frequency, accel_time, decel_time, motor_speed_est;
  logic [15:0] brake_start_frequency, out_frequency, dc_current;
  logic [7:0] curve_start_ratio, curve_end_ratio, magnetize_level, brake_hold_time, brake_duration;
  logic [7:0] brake_level, load_inertia_ratio, preheat_current_level, preheat_duty;
  logic [1:0] start_method_select, stop_method_select;
  logic [9:0] magnetize_duration;
  logic [11:0] motor_rated_current;
  int err_total, checks_done, n;

  dss_sequencer #(.TICK_CYCLES(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .run_cmd(run_cmd),
    .reverse_cmd(reverse_cmd), .cmd_frequency(cmd_frequency), .start_frequency(start_frequency),
    .max_frequency(max_frequency), .accel_time(accel_time), .decel_time(decel_time),
    .scurve_enable(scurve_enable), .curve_start_ratio(curve_start_ratio), .curve_end_ratio(curve_end_ratio),
    .start_method_select(start_method_select), .magnetize_duration(magnetize_duration),
    .magnetize_level(magnetize_level), .sensorless_mode(sensorless_mode), .motor_speed_est(motor_speed_est),
    .motor_reverse(motor_reverse), .stop_method_select(stop_method_select), .brake_hold_time(brake_hold_time),
    .brake_start_frequency(brake_start_frequency), .brake_duration(brake_duration), .brake_level(brake_level),
    .safety_stop_enable(safety_stop_enable), .power_fail(power_fail), .load_inertia_ratio(load_inertia_ratio),
    .motor_rated_current(motor_rated_current), .preheat_enable(preheat_enable),
    .preheat_input_assigned(preheat_input_assigned), .preheat_input(preheat_input),
    .preheat_current_level(preheat_current_level), .preheat_duty(preheat_duty), .param_write_req(param_write_req),
    .out_frequency(out_frequency), .gate_enable(gate_enable), .dc_inject(dc_inject), .dc_current(dc_current),
    .flux_brake(flux_brake), .running(running), .preheat_active(preheat_active), .param_write_ok(param_write_ok));
  dss_motor_model model (.clk(sys_clk), .gate_enable(gate_enable), .dc_inject(dc_inject),
    .out_frequency(out_frequency), .motor_speed_est(motor_speed_est), .motor_reverse(motor_reverse));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic start(input logic [1:0] m);
    @(posedge sys_clk) start_method_select <= m;
    reverse_cmd <= (m == 2'h2);
    run_cmd <= 1'b1;
    for (n = 0; n < 3000 && out_frequency !== cmd_frequency; n++) step(1);
    chk("run_freq", cmd_frequency, out_frequency);
  endtask

  task automatic stop(input logic [1:0] m);
    @(posedge sys_clk) stop_method_select <= m;
    run_cmd <= 1'b0;
    step(3);
  endtask

  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      start(2'(k));
      if (k == 0) chk("accel", 16'h0001, 16'(n >= 185 && n <= 225));
      stop(2'(k));
      chk("gate", 16'(k != 2), 16'(gate_enable));
      chk("flux", 16'(k == 3), 16'(flux_brake));
      for (n = 0; n < 5000 && running !== 1'b0; n++) step(1);
      chk("stopped", 16'h0000, 16'(running));
    end
  endtask

  task automatic t_dcstart();
    @(posedge sys_clk) magnetize_duration <= 10'h001;
    start_method_select <= 2'h1;
    run_cmd <= 1'b1;
    step(3);
    chk("mag_dc", 16'h0001, 16'(dc_inject));
    chk("mag_freq", start_frequency, out_frequency);
    chk("mag_cur", 16'h0064, dc_current);
    for (n = 0; n < 2000 && dc_inject !== 1'b0; n++) step(1);
    chk("mag_time", 16'h0001, 16'(n >= 980 && n <= 1020));
    for (int k = 0; k < 2; k++) begin
      stop(2'h2);
      @(posedge sys_clk) magnetize_level <= k ? 8'h32 : 8'h00;
      sensorless_mode <= k[0];
      run_cmd <= 1'b1;
      step(3);
      chk("no_mag", 16'h0000, 16'(dc_inject));
    end
    stop(2'h2);
    @(posedge sys_clk) sensorless_mode <= 1'b0;
    magnetize_duration <= 10'h000;
  endtask

  task automatic t_brake();
    start(2'h0);
    stop(2'h1);
    for (n = 0; n < 1000 && gate_enable !== 1'b0; n++) step(1);
    chk("to_brake_f", 16'h0001, 16'(n >= 150 && n <= 215));
    chk("hold_dc", 16'h0000, 16'(dc_inject));
    for (n = 0; n < 2000 && dc_inject !== 1'b1; n++) step(1);
    chk("hold_time", 16'h0001, 16'(n >= 980 && n <= 1020));
    chk("brake_cur", 16'h00C8, dc_current);
    for (n = 0; n < 2000 && running !== 1'b0; n++) step(1);
    chk("brake_time", 16'h0001, 16'(n >= 980 && n <= 1020));
  endtask

  task automatic t_preheat();
    @(posedge sys_clk) preheat_input <= 1'b1;
    param_write_req <= 1'b1;
    step(8);
    chk("ph_on", 16'h0001, 16'(preheat_active));
    chk("ph_cur", 16'h0064, dc_current);
    chk("ph_wr", 16'h0000, 16'(param_write_ok));
    @(posedge sys_clk) run_cmd <= 1'b1;
    step(3);
    chk("ph_run", 16'h0000, 16'(preheat_active));
    stop(2'h2);
    step(8);
    chk("ph_again", 16'h0001, 16'(preheat_active));
    @(posedge sys_clk) preheat_input <= 1'b0;
    step(6);
    chk("ph_off", 16'h0000, 16'(dc_inject));
    chk("wr_ok", 16'h0001, 16'(param_write_ok));
  endtask

  task automatic t_safety();
    for (int k = 1; k >= 0; k--) begin
      @(posedge sys_clk) safety_stop_enable <= k[0];
      start(2'h0);
      @(posedge sys_clk) power_fail <= 1'b1;
      step(6);
      chk("pf_gate", 16'(k), 16'(gate_enable));
      for (n = 0; n < 3000 && running !== 1'b0; n++) step(1);
      chk("pf_stop", 16'h0000, 16'(running));
      if (k == 1) chk("pf_decel", 16'h0001, 16'(n >= 420 && n <= 540));
      @(posedge sys_clk) power_fail <= 1'b0;
      run_cmd <= 1'b0;
      step(4);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    {run_cmd, reverse_cmd, scurve_enable, sensorless_mode, safety_stop_enable, power_fail} = 6'h08;
    {preheat_enable, preheat_input_assigned, preheat_input, param_write_req} = 4'hC;
    {cmd_frequency, start_frequency, max_frequency} = {16'h03E8, 16'h00C8, 16'h1770};
    {accel_time, decel_time} = {16'h0001, 16'h0001};
    {curve_start_ratio, curve_end_ratio, magnetize_level, brake_hold_time, brake_duration} = 40'h32_32_32_01_01;
    {brake_level, load_inertia_ratio, preheat_current_level, preheat_duty} = 32'h64_0A_32_64;
    {start_method_select, stop_method_select, magnetize_duration} = 14'h0000;
    motor_rated_current = 12'h0C8;
    brake_start_frequency = 16'h012C;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    step(6);
    t_modes();
    t_dcstart();
    t_brake();
    t_preheat();
    t_safety();
    results();
  end
endmodule
